// ==== design/tecb_pkg.sv ====
// Constants for the timer/event counter with buzzer block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package tecb_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL0 = 8'h00;
  localparam logic [7:0] A_CNT0 = 8'h04;
  localparam logic [7:0] A_CTRL1 = 8'h08;
  localparam logic [7:0] A_CNT1L = 8'h0C;
  localparam logic [7:0] A_CNT1H = 8'h10;
  localparam logic [7:0] A_IRQEN = 8'h14;
  localparam logic [7:0] A_PORTB = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1C;
  // ==========================================================
  // Control register fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int RUN_BIT = 4;
  localparam int EDGE_BIT = 3;
  localparam int PSC_HI = 2;
  // Mode field encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_EVT = 2'h1;
  localparam logic [1:0] MODE_TMR = 2'h2;
  localparam logic [1:0] MODE_PW = 2'h3;
  // ==========================================================
  // Port B register fields
  localparam int PB_DATA0 = 0;
  localparam int PB_DATA1 = 1;
  localparam int PB_DIR0 = 2;
  localparam int PB_DIR1 = 3;
  localparam int PB_BUZ_EN = 4;
  localparam int PB_BUZ_SRC = 5;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] PORTB_RST = 6'h0C;
  localparam logic [1:0] IRQEN_RST = 2'h0;
  // Full counts
  localparam logic [7:0] MAX0 = 8'hFF;
  localparam logic [15:0] MAX1 = 16'hFFFF;
endpackage : tecb_pkg

// ==== design/tecb_top.sv ====
// Timer/event counter pair with buzzer output and AHB-Lite register slave.
// Assumes one 250 MHz clock, pins arriving asynchronously, single-slave bus.
// Functional notes
// - Mode 1,0 selects timer mode counting internal clock ticks.
// - Eight-bit counter timer clock is system clock over prescaler ratio.
// - Sixteen-bit counter uses system clock over four, no prescaler.
// - Counter advances only while run bit set; cleared run holds count.
// - Timer mode increments on falling edge of internal count clock.
// - Overflow raises request, reloads from preload, keeps counting.
// - Interrupt enable bit zero suppresses timer interrupt.
// - Enabled overflow interrupt acts as power-down wake source.
// - Mode 0,1 counts external pin transitions while run bit high.
// - Edge bit low counts rising edges, high counts falling edges.
// - Event counting continues in power down; overflow interrupts and wakes.
// - Mode 1,1 counts internal clock only while external pulse active.
// - Edge low measures low pulse; edge high measures high pulse.
// - Pulse end clears run bit and halts, residual count readable.
// - In timer and event modes only software changes run bit.
// - After automatic stop pin edges ignored until software sets run.
// - Pulse measurement starts and stops on detected edges, not levels.
// - Overflow during pulse measurement raises request and reloads.
// - Buzzer enabled: each selected overflow toggles output; second is inverse.
// - Buzzer drives only lines whose direction bits say output.
// - Buzzer active only while data bit zero is one; else both low.
// - Control: mode bits 7:6, run bit 4, edge bit 3, prescale 2:0.
// - Preload write when stopped loads counter; running, at next overflow.
// - Sixteen-bit low byte write buffered, committed on high byte write.
// - Pin transitions synchronised, recognised on the system clock without waiting for a count clock.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module tecb_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // External count pins
  input wire logic COUNT0_PIN,
  input wire logic COUNT1_PIN,
  // Interrupt requests and wake-up
  output logic IRQ0,
  output logic IRQ1,
  output logic WAKE,
  // Buzzer pins on port B lines zero and one
  output logic TONE_OUT_TRUE_O,
  output logic TONE_OUT_TRUE_OE,
  output logic TONE_OUT_INV_O,
  output logic TONE_OUT_INV_OE
);

  // ==========================================================
  // State
  typedef struct packed {
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic ready;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] cnt0;
    logic [7:0] pre0;
    logic [15:0] cnt1;
    logic [15:0] pre1;
    logic [7:0] lo_wbuf;
    logic [7:0] lo_rlatch;
    logic [1:0] irqen;
    logic [5:0] portb;
    logic [7:0] psc_cnt;
    logic [1:0] div4;
    logic [2:0] sy0;
    logic [2:0] sy1;
    logic act0;
    logic act1;
    logic buz;
    logic irq0;
    logic irq1;
    logic wake;
    logic t_o;
    logic t_oe;
    logic i_o;
    logic i_oe;
  } tecb_state_t;

  tecb_state_t s;
  tecb_state_t next_s;

  // ==========================================================
  // Per-counter control: {advance, pulse start, pulse end}
  function automatic logic [2:0] tecb_ctl(
    input logic [1:0] mode,
    input logic run,
    input logic edge_pol,
    input logic itick,
    input logic rise,
    input logic fall,
    input logic active
  );
    logic ev;
    logic st;
    logic sp;
    logic adv;
    ev = edge_pol ? fall : rise;
    st = run && (mode == tecb_pkg::MODE_PW) && !active
      && (edge_pol ? rise : fall);
    sp = run && (mode == tecb_pkg::MODE_PW) && active
      && (edge_pol ? fall : rise);
    case (mode)
      tecb_pkg::MODE_TMR: adv = run && itick;
      tecb_pkg::MODE_EVT: adv = run && ev;
      tecb_pkg::MODE_PW: adv = run && active && itick;
      default: adv = 1'b0;
    endcase
    return {adv, st, sp};
  endfunction : tecb_ctl

  // ==========================================================
  // Next-state logic
  logic [7:0] next_psc;
  logic [1:0] next_div;
  logic tick0;
  logic tick1;
  logic [2:0] c0;
  logic [2:0] c1;
  logic ov0;
  logic ov1;
  logic wr;
  logic rd;
  logic [7:0] wb;
  logic buz_ov;

  always_comb begin
    next_s = s;
    // Prescaler and fixed divider, ticks on the falling edge of the count clock
    next_psc = s.psc_cnt + 8'h01;
    next_div = s.div4 + 2'h1;
    next_s.psc_cnt = next_psc;
    next_s.div4 = next_div;
    tick0 = s.psc_cnt[s.ctrl0[tecb_pkg::PSC_HI:0]]
      && !next_psc[s.ctrl0[tecb_pkg::PSC_HI:0]];
    tick1 = s.div4[1] && !next_div[1];
    // Pin synchronisers; edges seen only on the later stages
    next_s.sy0 = {s.sy0[1:0], COUNT0_PIN};
    next_s.sy1 = {s.sy1[1:0], COUNT1_PIN};
    c0 = tecb_ctl(s.ctrl0[tecb_pkg::MODE_HI:tecb_pkg::MODE_LO], s.ctrl0[tecb_pkg::RUN_BIT],
      s.ctrl0[tecb_pkg::EDGE_BIT], tick0, s.sy0[1] && !s.sy0[2],
      !s.sy0[1] && s.sy0[2], s.act0);
    c1 = tecb_ctl(s.ctrl1[tecb_pkg::MODE_HI:tecb_pkg::MODE_LO], s.ctrl1[tecb_pkg::RUN_BIT],
      s.ctrl1[tecb_pkg::EDGE_BIT], tick1, s.sy1[1] && !s.sy1[2],
      !s.sy1[1] && s.sy1[2], s.act1);
    // Counter 0
    ov0 = c0[2] && (s.cnt0 == tecb_pkg::MAX0);
    if (ov0) begin
      next_s.cnt0 = s.pre0;
    end else if (c0[2]) begin
      next_s.cnt0 = s.cnt0 + 8'h01;
    end
    if (c0[0]) begin
      next_s.act0 = 1'b0;
      next_s.ctrl0[tecb_pkg::RUN_BIT] = 1'b0;
    end else if (c0[1]) begin
      next_s.act0 = 1'b1;
    end else if (!s.ctrl0[tecb_pkg::RUN_BIT]) begin
      next_s.act0 = 1'b0;
    end
    // Counter 1
    ov1 = c1[2] && (s.cnt1 == tecb_pkg::MAX1);
    if (ov1) begin
      next_s.cnt1 = s.pre1;
    end else if (c1[2]) begin
      next_s.cnt1 = s.cnt1 + 16'h0001;
    end
    if (c1[0]) begin
      next_s.act1 = 1'b0;
      next_s.ctrl1[tecb_pkg::RUN_BIT] = 1'b0;
    end else if (c1[1]) begin
      next_s.act1 = 1'b1;
    end else if (!s.ctrl1[tecb_pkg::RUN_BIT]) begin
      next_s.act1 = 1'b0;
    end
    // Interrupt request pulses and wake-up
    next_s.irq0 = ov0 && s.irqen[0];
    next_s.irq1 = ov1 && s.irqen[1];
    next_s.wake = (ov0 && s.irqen[0]) || (ov1 && s.irqen[1]);
    // ========================================================
    // Bus: address phase taken, one wait cycle, then data phase ends
    wr = s.ph_valid && s.ph_write;
    rd = s.ph_valid && !s.ph_write;
    wb = HWDATA[7:0];
    next_s.ready = 1'b1;
    next_s.ph_valid = 1'b0;
    if (HSEL && HREADY && HTRANS[1] && !s.ph_valid) begin
      next_s.ph_valid = 1'b1;
      next_s.ph_write = HWRITE;
      next_s.ph_addr = HADDR[7:0];
      next_s.ready = 1'b0;
    end
    if (rd) begin
      case (s.ph_addr)
        tecb_pkg::A_CTRL0: next_s.rdata = {24'h000000, s.ctrl0};
        tecb_pkg::A_CNT0: next_s.rdata = {24'h000000, s.cnt0};
        tecb_pkg::A_CTRL1: next_s.rdata = {24'h000000, s.ctrl1};
        tecb_pkg::A_CNT1L: next_s.rdata = {24'h000000, s.lo_rlatch};
        tecb_pkg::A_CNT1H: begin
          next_s.rdata = {24'h000000, s.cnt1[15:8]};
          next_s.lo_rlatch = s.cnt1[7:0];
        end
        tecb_pkg::A_IRQEN: next_s.rdata = {30'h00000000, s.irqen};
        tecb_pkg::A_PORTB: next_s.rdata = {26'h0000000, s.portb};
        tecb_pkg::A_STAT: next_s.rdata = {28'h0000000, s.act1, s.act0,
          s.ctrl1[tecb_pkg::RUN_BIT], s.ctrl0[tecb_pkg::RUN_BIT]};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (s.ph_addr)
        tecb_pkg::A_CTRL0: begin
          next_s.ctrl0 = {wb[7:6], 1'b0, wb[4:0]};
          next_s.act0 = 1'b0;
        end
        tecb_pkg::A_CNT0: begin
          next_s.pre0 = wb;
          if (!s.ctrl0[tecb_pkg::RUN_BIT]) begin
            next_s.cnt0 = wb;
          end
        end
        tecb_pkg::A_CTRL1: begin
          next_s.ctrl1 = {wb[7:6], 1'b0, wb[4:3], 3'h0};
          next_s.act1 = 1'b0;
        end
        tecb_pkg::A_CNT1L: next_s.lo_wbuf = wb;
        tecb_pkg::A_CNT1H: begin
          next_s.pre1 = {wb, s.lo_wbuf};
          if (!s.ctrl1[tecb_pkg::RUN_BIT]) begin
            next_s.cnt1 = {wb, s.lo_wbuf};
          end
        end
        tecb_pkg::A_IRQEN: next_s.irqen = wb[1:0];
        tecb_pkg::A_PORTB: next_s.portb = wb[5:0];
        default: next_s.portb = s.portb;
      endcase
    end
    // ========================================================
    // Buzzer on port B lines zero and one
    buz_ov = s.portb[tecb_pkg::PB_BUZ_SRC] ? ov1 : ov0;
    if (!s.portb[tecb_pkg::PB_DATA0]) begin
      next_s.buz = 1'b0;
    end else if (buz_ov) begin
      next_s.buz = !s.buz;
    end
    if (s.portb[tecb_pkg::PB_BUZ_EN]) begin
      next_s.t_o = s.portb[tecb_pkg::PB_DATA0] && s.buz;
      next_s.i_o = s.portb[tecb_pkg::PB_DATA0] && !s.buz;
    end else begin
      next_s.t_o = s.portb[tecb_pkg::PB_DATA0];
      next_s.i_o = s.portb[tecb_pkg::PB_DATA1];
    end
    next_s.t_oe = !s.portb[tecb_pkg::PB_DIR0];
    next_s.i_oe = !s.portb[tecb_pkg::PB_DIR1];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.ready <= 1'b1;
      s.ctrl0 <= tecb_pkg::CTRL_RST;
      s.ctrl1 <= tecb_pkg::CTRL_RST;
      s.portb <= tecb_pkg::PORTB_RST;
      s.irqen <= tecb_pkg::IRQEN_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign HRDATA = s.rdata;
  assign HREADYOUT = s.ready;
  assign HRESP = 1'b0;
  assign IRQ0 = s.irq0;
  assign IRQ1 = s.irq1;
  assign WAKE = s.wake;
  assign TONE_OUT_TRUE_O = s.t_o;
  assign TONE_OUT_TRUE_OE = s.t_oe;
  assign TONE_OUT_INV_O = s.i_o;
  assign TONE_OUT_INV_OE = s.i_oe;

endmodule : tecb_top

// ==== dv/tb_top.sv ====
// Self-checking bench for tecb_top.
// Assumes the bench is the only bus master.
`timescale 1ns/1ps
module tb_top;
  // ====
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, q2;
  logic rdy, resp, pin0, pin1, irq0, irq1, wake, t_o, t_oe, i_o, i_oe;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  tecb_top uut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata),
    .HREADYOUT(rdy), .HRESP(resp), .COUNT0_PIN(pin0), .COUNT1_PIN(pin1), .IRQ0(irq0),
    .IRQ1(irq1), .WAKE(wake), .TONE_OUT_TRUE_O(t_o), .TONE_OUT_TRUE_OE(t_oe),
    .TONE_OUT_INV_O(i_o), .TONE_OUT_INV_OE(i_oe));
  tecb_pin_src #(.IDLE(1'b1)) src0 (.clk(clk), .pin(pin0));
  tecb_pin_src #(.IDLE(1'b0)) src1 (.clk(clk), .pin(pin1));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end
  // ====
  // Shared tasks
  task automatic conclude();
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic rd16(input logic [15:0] e);
    rdc(tecb_pkg::A_CNT1H, {24'h0, e[15:8]});
    rdc(tecb_pkg::A_CNT1L, {24'h0, e[7:0]});
  endtask : rd16
  task automatic wirq(input logic k, input logic e);
    logic s;
    logic w;
    s = 1'b0;
    w = 1'b0;
    repeat (40) begin
      @(posedge clk);
      s = s | (k ? irq1 : irq0);
      w = w | wake;
    end
    chk({31'h0, s}, {31'h0, e});
    chk({31'h0, w}, {31'h0, e});
  endtask : wirq
  // ====
  // Scenarios
  task automatic t_reset();
    rdc(tecb_pkg::A_CTRL0, 32'h0);
    chk({31'h0, resp}, 32'h0);
    rdc(tecb_pkg::A_PORTB, {26'h0, tecb_pkg::PORTB_RST});
    wr(8'h40, 32'hFF);
    rdc(8'h40, 32'h0);
  endtask : t_reset
  task automatic t_timer();
    wr(tecb_pkg::A_CNT0, 32'hFD);
    rdc(tecb_pkg::A_CNT0, 32'hFD);
    wr(tecb_pkg::A_CTRL0, 32'h90);
    wirq(1'b0, 1'b0);
    wr(tecb_pkg::A_IRQEN, 32'h1);
    wirq(1'b0, 1'b1);
    wr(tecb_pkg::A_CTRL0, 32'h80);
    bus(1'b0, tecb_pkg::A_CNT0, 32'h0);
    q2 = q;
    repeat (20) @(posedge clk);
    rdc(tecb_pkg::A_CNT0, q2);
    wr(tecb_pkg::A_CTRL0, 32'h10);
    repeat (20) @(posedge clk);
    rdc(tecb_pkg::A_CNT0, q2);
  endtask : t_timer
  task automatic t_event();
    wr(tecb_pkg::A_CNT1L, 32'hFE);
    wr(tecb_pkg::A_CNT1H, 32'hFF);
    rd16(16'hFFFE);
    wr(tecb_pkg::A_IRQEN, 32'h3);
    wr(tecb_pkg::A_CTRL1, 32'h50);
    src1.drive(1'b1, 10);
    rd16(16'hFFFF);
    src1.drive(1'b0, 10);
    rd16(16'hFFFF);
    wr(tecb_pkg::A_CTRL1, 32'h58);
    src1.drive(1'b1, 10);
    rd16(16'hFFFF);
    fork
      src1.drive(1'b0, 10);
      wirq(1'b1, 1'b1);
    join
    rd16(16'hFFFE);
  endtask : t_event
  task automatic t_pulse();
    wr(tecb_pkg::A_CTRL0, 32'h0);
    wr(tecb_pkg::A_CNT0, 32'h0);
    wr(tecb_pkg::A_CTRL0, 32'hD0);
    src0.drive(1'b0, 40);
    src0.drive(1'b1, 10);
    rdc(tecb_pkg::A_CTRL0, 32'hC0);
    bus(1'b0, tecb_pkg::A_CNT0, 32'h0);
    q2 = q;
    chk({31'h0, q > 32'h0F && q < 32'h19}, 32'h1);
    src0.drive(1'b0, 40);
    src0.drive(1'b1, 10);
    rdc(tecb_pkg::A_CNT0, q2);
  endtask : t_pulse
  task automatic t_tone();
    wr(tecb_pkg::A_CTRL0, 32'h0);
    wr(tecb_pkg::A_CNT0, 32'hFF);
    wr(tecb_pkg::A_CTRL0, 32'h90);
    wr(tecb_pkg::A_PORTB, 32'h11);
    repeat (3) @(posedge clk);
    chk({30'h0, t_oe, i_oe}, 32'h3);
    chk({31'h0, t_o ^ i_o}, 32'h1);
    q2 = {31'h0, t_o};
    for (int i = 0; i < 30 && t_o === q2[0]; i++) @(posedge clk);
    chk({31'h0, t_o}, {31'h0, ~q2[0]});
    wr(tecb_pkg::A_PORTB, 32'h12);
    repeat (3) @(posedge clk);
    chk({30'h0, t_o, i_o}, 32'h0);
    wr(tecb_pkg::A_PORTB, 32'h1D);
    repeat (3) @(posedge clk);
    chk({30'h0, t_oe, i_oe}, 32'h0);
  endtask : t_tone
  // ====
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_timer();
    t_event();
    t_pulse();
    t_tone();
    conclude();
  end
endmodule : tb_top

// ==== dv/tecb_assertions.sv ====
// Concurrent checks on the ports of tecb_top.
// Assumes one slave, so HREADY is HREADYOUT.
`timescale 1ns/1ps
module tecb_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Events and tone enables
  input wire logic IRQ0,
  input wire logic IRQ1,
  input wire logic WAKE,
  input wire logic TONE_OUT_TRUE_OE,
  input wire logic TONE_OUT_INV_OE
);
  // ====
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  resp_okay_a: assert property (HRESP == 1'b0) else $error("response not okay");
  bus_take_a: assert property (HSEL && HREADY && HTRANS[1] && HREADYOUT |=> !HREADYOUT)
    else $error("transfer not taken");
  bus_back_a: assert property (!HREADYOUT |=> HREADYOUT) else $error("wait too long");
  wake_src_a: assert property (WAKE == (IRQ0 || IRQ1)) else $error("wake mismatch");
  irq0_single_a: assert property (IRQ0 |=> !IRQ0) else $error("irq0 too wide");
  irq1_gap_a: assert property (IRQ1 |=> !IRQ1 [*3]) else $error("irq1 too close");
  oe_true_a: assert property ($changed(TONE_OUT_TRUE_OE) |->
    !$past(HREADYOUT) || !$past(HREADYOUT, 2)) else $error("true enable moved");
  oe_inv_a: assert property ($changed(TONE_OUT_INV_OE) |->
    !$past(HREADYOUT) || !$past(HREADYOUT, 2)) else $error("inverse enable moved");
  cover property (IRQ0);
  cover property (IRQ1);
  cover property (TONE_OUT_TRUE_OE && TONE_OUT_INV_OE);
endmodule : tecb_assertions
bind tecb_top tecb_assertions u_chk (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ0(IRQ0), .IRQ1(IRQ1),
  .WAKE(WAKE), .TONE_OUT_TRUE_OE(TONE_OUT_TRUE_OE), .TONE_OUT_INV_OE(TONE_OUT_INV_OE));

// ==== dv/tecb_pin_src.sv ====
// External event or pulse source on one count pin.
// Assumes each level is held for more than two clocks.
`timescale 1ns/1ps
module tecb_pin_src #(parameter logic IDLE = 1'b0) (
  // Clock
  input wire logic clk,
  // Driven pin
  output logic pin
);
  initial pin = IDLE;
  // Pin is used only as a device input here
  task automatic drive(input logic lvl, input int n);
    @(posedge clk);
    pin <= lvl;
    repeat (n) @(posedge clk);
  endtask : drive
endmodule : tecb_pin_src
